// ==== hw/mmd_pkg.sv ====
package mmd_pkg;

  // Address space
  localparam int ADDR_W = 16;
  localparam int SPACE_BYTES = 65536;

  // Zero-page register area
  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h003F;

  // On-chip RAM
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h023F;

  // Flash routine ROM: jump table, first and second routine segments
  localparam logic [15:0] JUMP_LO = 16'h1000;
  localparam logic [15:0] JUMP_HI = 16'h101F;
  localparam logic [15:0] ROUT1_LO = 16'h1020;
  localparam logic [15:0] ROUT1_HI = 16'h121F;
  localparam logic [15:0] ROUT2_LO = 16'h137E;
  localparam logic [15:0] ROUT2_HI = 16'h13FF;

  // User flash array; its top byte is the extended security byte
  localparam logic [15:0] FLASH_LO = 16'hC000;
  localparam logic [15:0] FLASH_HI = 16'hFDFF;
  localparam logic [15:0] EXT_SEC_ADDR = 16'hFDFF;

  // High system-register page
  localparam logic [15:0] SYS_LO = 16'hFE00;
  localparam logic [15:0] SYS_HI = 16'hFE0C;
  localparam logic [15:0] RSV_LO = 16'hFE0D;
  localparam logic [15:0] RSV_HI = 16'hFE1F;

  // Monitor ROM
  localparam logic [15:0] MON_LO = 16'hFE20;
  localparam logic [15:0] MON_HI = 16'hFF7D;

  // Single-byte locations
  localparam logic [15:0] BLK_PROT_ADDR = 16'hFF7E;
  localparam logic [15:0] TRIM_5V_ADDR = 16'hFF80;
  localparam logic [15:0] TRIM_3V_ADDR = 16'hFF81;

  // Vector area and the security bytes inside it
  localparam logic [15:0] VEC_LO = 16'hFFDC;
  localparam logic [15:0] VEC_HI = 16'hFFFF;
  localparam logic [15:0] SEC_LO = 16'hFFF6;
  localparam logic [15:0] SEC_HI = 16'hFFFD;

  // System register selects, in order of the sysreg_sel bits
  localparam int SYSREG_N = 11;
  localparam logic [15:0] SYSREG_ADDR [SYSREG_N] = '{
    16'hFE00, // break_status
    16'hFE01, // reset_cause_status
    16'hFE03, // break_flag_control
    16'hFE04, // interrupt status 1
    16'hFE05, // interrupt status 2
    16'hFE06, // interrupt status 3
    16'hFE08, // flash_control
    16'hFE09, // break address high
    16'hFE0A, // break address low
    16'hFE0B, // break_control_status
    16'hFE0C  // low_voltage_status
  };

  localparam int REGION_N = 13;

  typedef enum logic [3:0] {
    REG_UNIMPL = 4'h0,
    REG_IO = 4'h1,
    REG_RAM = 4'h2,
    REG_JUMP = 4'h3,
    REG_ROUTINE = 4'h4,
    REG_FLASH = 4'h5,
    REG_SYSREG = 4'h6,
    REG_RESERVED = 4'h7,
    REG_MON_ROM = 4'h8,
    REG_BLK_PROT = 4'h9,
    REG_TRIM_5V = 4'hA,
    REG_TRIM_3V = 4'hB,
    REG_VECTOR = 4'hC
  } mmd_region_t;

endpackage : mmd_pkg

// ==== hw/mmd_dec_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface mmd_dec_if;
  logic [15:0] addr;
  mmd_pkg::mmd_region_t region;
  logic [15:0] offset;

  modport classifier (input addr, output region, output offset);
  modport user (output addr, input region, input offset);
endinterface : mmd_dec_if

`default_nettype wire

// ==== hw/mmd_classify.sv ====
`timescale 1ns/10ps
`default_nettype none

module mmd_classify (
  mmd_dec_if.classifier dec // Address in, region and offset out
);

  function automatic logic in_range(
    input logic [15:0] a,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb begin
    dec.region = mmd_pkg::REG_UNIMPL; // R01 R13
    dec.offset = 16'h0000;
    if (in_range(dec.addr, mmd_pkg::IO_LO, mmd_pkg::IO_HI)) begin // R04
      dec.region = mmd_pkg::REG_IO;
      dec.offset = dec.addr - mmd_pkg::IO_LO;
    end else if (in_range(dec.addr, mmd_pkg::RAM_LO,
                          mmd_pkg::RAM_HI)) begin // R05
      dec.region = mmd_pkg::REG_RAM;
      dec.offset = dec.addr - mmd_pkg::RAM_LO;
    end else if (in_range(dec.addr, mmd_pkg::JUMP_LO,
                          mmd_pkg::JUMP_HI)) begin // R09
      dec.region = mmd_pkg::REG_JUMP;
      dec.offset = dec.addr - mmd_pkg::JUMP_LO;
    end else if (in_range(dec.addr, mmd_pkg::ROUT1_LO,
                          mmd_pkg::ROUT1_HI)) begin // R09
      dec.region = mmd_pkg::REG_ROUTINE;
      dec.offset = dec.addr - mmd_pkg::ROUT1_LO;
    end else if (in_range(dec.addr, mmd_pkg::ROUT2_LO,
                          mmd_pkg::ROUT2_HI)) begin // R09
      dec.region = mmd_pkg::REG_ROUTINE;
      dec.offset = dec.addr - mmd_pkg::ROUT2_LO;
    end else if (in_range(dec.addr, mmd_pkg::FLASH_LO,
                          mmd_pkg::FLASH_HI)) begin // R06
      dec.region = mmd_pkg::REG_FLASH;
      dec.offset = dec.addr - mmd_pkg::FLASH_LO;
    end else if (in_range(dec.addr, mmd_pkg::SYS_LO,
                          mmd_pkg::SYS_HI)) begin // R10
      // Holes at the two single reserved bytes are refined by the top
      dec.region = mmd_pkg::REG_SYSREG;
      dec.offset = dec.addr - mmd_pkg::SYS_LO;
    end else if (in_range(dec.addr, mmd_pkg::RSV_LO,
                          mmd_pkg::RSV_HI)) begin // R03
      dec.region = mmd_pkg::REG_RESERVED;
      dec.offset = dec.addr - mmd_pkg::RSV_LO;
    end else if (in_range(dec.addr, mmd_pkg::MON_LO,
                          mmd_pkg::MON_HI)) begin // R08
      dec.region = mmd_pkg::REG_MON_ROM;
      dec.offset = dec.addr - mmd_pkg::MON_LO;
    end else if (dec.addr == mmd_pkg::BLK_PROT_ADDR) begin // R11
      dec.region = mmd_pkg::REG_BLK_PROT;
    end else if (dec.addr == mmd_pkg::TRIM_5V_ADDR) begin // R11
      dec.region = mmd_pkg::REG_TRIM_5V;
    end else if (dec.addr == mmd_pkg::TRIM_3V_ADDR) begin // R11
      dec.region = mmd_pkg::REG_TRIM_3V;
    end else if (in_range(dec.addr, mmd_pkg::VEC_LO,
                          mmd_pkg::VEC_HI)) begin // R07
      dec.region = mmd_pkg::REG_VECTOR;
      dec.offset = dec.addr - mmd_pkg::VEC_LO;
    end
  end

endmodule : mmd_classify

`default_nettype wire

// ==== hw/mmd_decoder.sv ====
// Summary of operation
// R01: Decode whole 64 Kbyte space, every address
// R02: Flag unimplemented accesses to reset logic
// R03: Software avoids reserved bytes; no defined effect
// R04: 0000-003F selects zero-page registers
// R05: 512-byte RAM follows zero page
// R06: C000-FDFF selects 15,872-byte user flash
// R07: Top 36 bytes select vector area
// R08: FE20-FF7D selects read-only monitor ROM
// R09: Jump table, routine space, upper routine segment
// R10: Individual high-page system register selects
// R11: Block protect and two trim byte selects
// R12: FFF6-FFFD flagged as eight security bytes
// R13: All gaps decode as unimplemented
`timescale 1ns/10ps
`default_nettype none

module mmd_decoder (
  input wire logic clk_sys, // 10 MHz bus clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [15:0] cpu_addr, // CPU address bus
  input wire logic cpu_valid, // Access strobe for this cycle
  input wire logic cpu_write, // 1 write, 0 read
  output logic access_valid, // Registered copy of cpu_valid
  output logic [3:0] region_code, // Decoded region of the access
  output logic [12:0] region_sel, // One-hot region select
  output logic [15:0] region_offset, // Byte offset inside region
  output logic [10:0] sysreg_sel, // One-hot system register select
  output logic ext_security_sel, // Top flash byte accessed
  output logic security_sel, // One of eight security bytes
  output logic [2:0] security_index, // Which security byte
  output logic illegal_addr, // Pulse to reset logic
  output logic rom_write // Pulse: write aimed at ROM, ignored
);

  mmd_dec_if dec ();

  logic [mmd_pkg::SYSREG_N-1:0] sysreg_hit;
  logic sys_hole;
  mmd_pkg::mmd_region_t region_eff;

  // Per-access decode flags
  logic unimpl_hit;
  logic rom_hit;
  logic sec_hit;
  logic ext_sec_hit;

  logic access_valid_reg;
  logic access_valid_next;
  logic [3:0] region_code_reg;
  logic [3:0] region_code_next;
  logic [12:0] region_sel_reg;
  logic [12:0] region_sel_next;
  logic [15:0] region_offset_reg;
  logic [15:0] region_offset_next;
  logic [10:0] sysreg_sel_reg;
  logic [10:0] sysreg_sel_next;
  logic ext_sec_reg;
  logic ext_sec_next;
  logic security_sel_reg;
  logic security_sel_next;
  logic [2:0] security_index_reg;
  logic [2:0] security_index_next;
  logic illegal_addr_reg;
  logic illegal_addr_next;
  logic rom_write_reg;
  logic rom_write_next;

  function automatic logic is_rom(input mmd_pkg::mmd_region_t r);
    is_rom = (r == mmd_pkg::REG_MON_ROM) || (r == mmd_pkg::REG_JUMP) ||
             (r == mmd_pkg::REG_ROUTINE);
  endfunction : is_rom

  function automatic logic is_security(input logic [15:0] a);
    is_security = (a >= mmd_pkg::SEC_LO) && (a <= mmd_pkg::SEC_HI);
  endfunction : is_security

  function automatic logic [mmd_pkg::REGION_N-1:0] region_onehot(
    input mmd_pkg::mmd_region_t r
  );
    region_onehot = '0;
    region_onehot[r] = 1'b1;
  endfunction : region_onehot

  assign dec.addr = cpu_addr;

  mmd_classify u_classify (
    .dec(dec)
  );

  // Exact match against each documented system register address
  genvar gi;
  generate
    for (gi = 0; gi < mmd_pkg::SYSREG_N; gi++) begin : g_sysreg
      assign sysreg_hit[gi] = (cpu_addr == mmd_pkg::SYSREG_ADDR[gi]); // R10
    end
  endgenerate

  // Inside FE00-FE0C but no register there: the two reserved bytes
  assign sys_hole = (dec.region == mmd_pkg::REG_SYSREG) &&
                    (sysreg_hit == '0);

  always_comb begin
    region_eff = dec.region;
    if (sys_hole) begin
      region_eff = mmd_pkg::REG_RESERVED; // R03
    end
  end

  // Decode flags shared by the register groups below
  assign unimpl_hit = (region_eff == mmd_pkg::REG_UNIMPL); // R02 R13
  assign rom_hit = is_rom(region_eff); // R08 R09
  assign sec_hit = is_security(cpu_addr); // R12
  // Top flash byte doubles as the extended security byte
  assign ext_sec_hit = (cpu_addr == mmd_pkg::EXT_SEC_ADDR); // R06

  // Access echo: a registered copy of the strobe
  always_comb begin
    access_valid_next = cpu_valid; // R01
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      access_valid_reg <= 1'b0;
    end else begin
      access_valid_reg <= access_valid_next;
    end
  end

  // Event group: one-cycle pulses per access
  always_comb begin
    illegal_addr_next = 1'b0;
    rom_write_next = 1'b0;
    if (cpu_valid) begin
      // Unimplemented space raises the illegal address event
      illegal_addr_next = unimpl_hit; // R02 R13
      // ROM ignores writes; the attempt is reported, not stored
      rom_write_next = cpu_write && rom_hit; // R08 R09
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      illegal_addr_reg <= 1'b0;
      rom_write_reg <= 1'b0;
    end else begin
      illegal_addr_reg <= illegal_addr_next;
      rom_write_reg <= rom_write_next;
    end
  end

  // Region group: code, one-hot select and byte offset
  always_comb begin
    region_code_next = 4'h0;
    region_sel_next = 13'h0000;
    region_offset_next = 16'h0000;
    if (cpu_valid) begin
      region_code_next = region_eff; // R01
      region_sel_next = region_onehot(region_eff); // R01
      region_offset_next = dec.offset;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      region_code_reg <= 4'h0;
      region_sel_reg <= 13'h0000;
      region_offset_reg <= 16'h0000;
    end else begin
      region_code_reg <= region_code_next;
      region_sel_reg <= region_sel_next;
      region_offset_reg <= region_offset_next;
    end
  end

  // Select group: system registers and the top flash byte
  always_comb begin
    sysreg_sel_next = 11'h000;
    ext_sec_next = 1'b0;
    if (cpu_valid) begin
      sysreg_sel_next = sysreg_hit; // R10
      ext_sec_next = ext_sec_hit; // R06
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sysreg_sel_reg <= 11'h000;
      ext_sec_reg <= 1'b0;
    end else begin
      sysreg_sel_reg <= sysreg_sel_next;
      ext_sec_reg <= ext_sec_next;
    end
  end

  // Security group: which of the eight security bytes is touched
  always_comb begin
    security_sel_next = 1'b0;
    security_index_next = 3'h0;
    if (cpu_valid && sec_hit) begin
      security_sel_next = 1'b1; // R12
      security_index_next = 3'(cpu_addr - mmd_pkg::SEC_LO); // R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      security_sel_reg <= 1'b0;
      security_index_reg <= 3'h0;
    end else begin
      security_sel_reg <= security_sel_next;
      security_index_reg <= security_index_next;
    end
  end

  assign access_valid = access_valid_reg;
  assign region_code = region_code_reg;
  assign region_sel = region_sel_reg;
  assign region_offset = region_offset_reg;
  assign sysreg_sel = sysreg_sel_reg;
  assign ext_security_sel = ext_sec_reg;
  assign security_sel = security_sel_reg;
  assign security_index = security_index_reg;
  assign illegal_addr = illegal_addr_reg;
  assign rom_write = rom_write_reg;

endmodule : mmd_decoder

`default_nettype wire

// ==== test/mmd_decoder_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_asserts (
  input wire logic clk_sys, // Bus clock
  input wire logic nrst, // Sync reset, active low
  input wire logic [15:0] cpu_addr, // Address
  input wire logic cpu_valid, // Strobe
  input wire logic cpu_write, // Write flag
  input wire logic access_valid, // Access seen
  input wire logic [3:0] region_code, // Region
  input wire logic [12:0] region_sel, // One-hot region
  input wire logic [15:0] region_offset, // Offset
  input wire logic [10:0] sysreg_sel, // Register select
  input wire logic ext_security_sel, // Flash top byte
  input wire logic security_sel, // Security byte
  input wire logic [2:0] security_index, // Security index
  input wire logic illegal_addr, // Illegal pulse
  input wire logic rom_write // ROM write pulse
);
  logic gap;
  assign gap = cpu_addr inside {[16'h0240:16'h0FFF], [16'h1220:16'h137D],
    [16'h1400:16'hBFFF], 16'hFF7F, [16'hFF82:16'hFFDB]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_acc(logic [15:0] lo, logic [15:0] hi);
    cpu_valid && cpu_addr >= lo && cpu_addr <= hi;
  endsequence
  io_select_a:
    assert property (s_acc(16'h0000, 16'h003F) |=> region_code == 4'h1
      && region_offset == $past(cpu_addr)) else $error("io decode");
  ram_select_a:
    assert property (s_acc(16'h0040, 16'h023F) |=> region_code == 4'h2
      && region_offset == $past(cpu_addr) - 16'h0040) else $error("ram");
  flash_select_a:
    assert property (s_acc(16'hC000, 16'hFDFF) |=> region_code == 4'h5
      && region_offset == $past(cpu_addr) - 16'hC000) else $error("flash");
  vector_select_a:
    assert property (s_acc(16'hFFDC, 16'hFFFF) |=> region_code == 4'hC
      && region_offset == $past(cpu_addr) - 16'hFFDC) else $error("vector");
  monitor_rom_a:
    assert property (s_acc(16'hFE20, 16'hFF7D) |=> region_code == 4'h8
      && rom_write == $past(cpu_write)) else $error("monitor rom");
  jump_table_a:
    assert property (s_acc(16'h1000, 16'h101F) |=> region_code == 4'h3)
      else $error("jump table");
  routine_rom_a:
    assert property (s_acc(16'h1020, 16'h121F) |=> region_code == 4'h4)
      else $error("routine rom");
  last_sysreg_a:
    assert property (s_acc(16'hFE0C, 16'hFE0C) |=> region_code == 4'h6
      && sysreg_sel == 11'h400) else $error("sysreg select");
  trim_select_a:
    assert property (s_acc(16'hFF80, 16'hFF81) |=> region_code ==
      ($past(cpu_addr[0]) ? 4'hB : 4'hA)) else $error("trim select");
  security_bytes_a:
    assert property (s_acc(16'hFFF6, 16'hFFFD) |=> security_sel &&
      security_index == $past(cpu_addr[2:0]) - 3'h6) else $error("security");
  illegal_gap_a:
    assert property (cpu_valid && gap |=> illegal_addr &&
      region_sel == 13'h0001) else $error("gap not illegal");
  legal_quiet_a:
    assert property (cpu_valid && !gap |=> !illegal_addr)
      else $error("false illegal");
  onehot_sel_a:
    assert property (cpu_valid |=> access_valid && $onehot(region_sel))
      else $error("region select not one-hot");
endmodule : mmd_decoder_asserts
`default_nettype wire

// ==== test/mmd_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mmd_cpu_model (
  input wire logic clk_sys, // Bus clock
  output logic [15:0] cpu_addr, // Address
  output logic cpu_valid, // Strobe
  output logic cpu_write // Write flag
);
  initial begin
    cpu_addr = 16'h0000;
    cpu_valid = 1'b0;
    cpu_write = 1'b0;
  end
  // One access; returns just after the answering edge
  task access(input logic [15:0] a, input logic w);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_valid <= 1'b1;
    cpu_write <= w;
    @(posedge clk_sys);
    cpu_valid <= 1'b0;
    // Released lines do not keep the last value
    cpu_addr <= ~a;
    cpu_write <= ~w;
    #1;
  endtask : access
endmodule : mmd_cpu_model
`default_nettype wire

// ==== test/memory_map_address_decoder_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module memory_map_address_decoder_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] cpu_addr;
  logic cpu_valid;
  logic cpu_write;
  logic access_valid;
  logic [3:0] region_code;
  logic [12:0] region_sel;
  logic [15:0] region_offset;
  logic [10:0] sysreg_sel;
  logic ext_security_sel;
  logic security_sel;
  logic [2:0] security_index;
  logic illegal_addr;
  logic rom_write;
  int num_errors = 0;
  int num_checks = 0;
  always #50 clk_sys = ~clk_sys;
  mmd_cpu_model u_cpu (.clk_sys, .cpu_addr, .cpu_valid, .cpu_write);
  mmd_decoder DUT (.clk_sys, .nrst, .cpu_addr, .cpu_valid, .cpu_write,
    .access_valid, .region_code, .region_sel, .region_offset, .sysreg_sel,
    .ext_security_sel, .security_sel, .security_index, .illegal_addr,
    .rom_write);
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task acc(input logic [15:0] a, input logic w, input logic [3:0] c,
    input logic [15:0] o);
    u_cpu.access(a, w);
    cmp("access_valid", 16'h0001, {15'h0, access_valid});
    cmp("region_code", {12'h0, c}, {12'h0, region_code});
    cmp("region_sel", 16'h0001 << c, {3'h0, region_sel});
    cmp("region_offset", o, region_offset);
    cmp("illegal_addr", {15'h0, c == 4'h0}, {15'h0, illegal_addr});
    cmp("rom_write", {15'h0, w && c inside {4'h3, 4'h4, 4'h8}},
      {15'h0, rom_write});
  endtask : acc
  task t_low;
    acc(16'h0000, 1'b0, 4'h1, 16'h0000);
    acc(16'h003F, 1'b1, 4'h1, 16'h003F);
    acc(16'h0040, 1'b0, 4'h2, 16'h0000);
    acc(16'h023F, 1'b1, 4'h2, 16'h01FF);
    @(posedge clk_sys);
    #1;
    cmp("idle_sel", 16'h0000, {3'h0, region_sel});
  endtask : t_low
  task t_rom;
    acc(16'h1000, 1'b1, 4'h3, 16'h0000);
    acc(16'h101F, 1'b0, 4'h3, 16'h001F);
    acc(16'h1020, 1'b1, 4'h4, 16'h0000);
    acc(16'h121F, 1'b0, 4'h4, 16'h01FF);
    acc(16'h137E, 1'b0, 4'h4, 16'h0000);
    acc(16'h13FF, 1'b1, 4'h4, 16'h0081);
    acc(16'hFE20, 1'b1, 4'h8, 16'h0000);
    acc(16'hFF7D, 1'b0, 4'h8, 16'h015D);
  endtask : t_rom
  task t_flash;
    acc(16'hC000, 1'b1, 4'h5, 16'h0000);
    cmp("ext_security_sel", 16'h0000, {15'h0, ext_security_sel});
    acc(16'hFDFF, 1'b0, 4'h5, 16'h3DFF);
    cmp("ext_security_sel", 16'h0001, {15'h0, ext_security_sel});
    acc(16'hFFDC, 1'b0, 4'hC, 16'h0000);
    acc(16'hFFFF, 1'b1, 4'hC, 16'h0023);
  endtask : t_flash
  task t_single;
    acc(16'hFF7E, 1'b0, 4'h9, 16'h0000);
    acc(16'hFF80, 1'b0, 4'hA, 16'h0000);
    acc(16'hFF81, 1'b1, 4'hB, 16'h0000);
  endtask : t_single
  task t_sys;
    logic [15:0] a;
    for (int i = 0; i < mmd_pkg::SYSREG_N; i++) begin
      a = mmd_pkg::SYSREG_ADDR[i];
      acc(a, 1'b0, 4'h6, a - 16'hFE00);
      cmp("sysreg_sel", 16'h0001 << i, {5'h0, sysreg_sel});
    end
  endtask : t_sys
  task t_sec;
    logic [15:0] a;
    for (int i = 0; i < 8; i++) begin
      a = 16'hFFF6 + i[15:0];
      acc(a, 1'b0, 4'hC, a - 16'hFFDC);
      cmp("security_sel", 16'h0001, {15'h0, security_sel});
      cmp("security_index", i[15:0], {13'h0, security_index});
    end
    acc(16'hFFFE, 1'b0, 4'hC, 16'h0022);
    cmp("security_sel", 16'h0000, {15'h0, security_sel});
  endtask : t_sec
  task t_gap;
    static logic [15:0] g [9] = '{16'h0240, 16'h0FFF, 16'h1220, 16'h137D,
      16'h1400, 16'hBFFF, 16'hFF7F, 16'hFF82, 16'hFFDB};
    foreach (g[i]) acc(g[i], 1'b0, 4'h0, 16'h0000);
  endtask : t_gap
  task t_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    u_cpu.access(16'h0240, 1'b0);
    cmp("reset_illegal", 16'h0000, {15'h0, illegal_addr});
    cmp("reset_valid", 16'h0000, {15'h0, access_valid});
    @(posedge clk_sys);
    nrst <= 1'b1;
    acc(16'h1220, 1'b0, 4'h0, 16'h0000);
  endtask : t_reset
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_low();
    t_rom();
    t_flash();
    t_single();
    t_sys();
    t_sec();
    t_gap();
    t_reset();
    test_done();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
endmodule : memory_map_address_decoder_test
bind mmd_decoder mmd_decoder_asserts u_chk (.clk_sys, .nrst, .cpu_addr,
  .cpu_valid, .cpu_write, .access_valid, .region_code, .region_sel,
  .region_offset, .sysreg_sel, .ext_security_sel, .security_sel,
  .security_index, .illegal_addr, .rom_write);
`default_nettype wire
